// ### hdl/fspc_params.svh
// register offsets, key values, random code addresses and timing counts
`ifndef FSPC_PARAMS_SVH
`define FSPC_PARAMS_SVH
`define FSPC_ADDR_AREA     8'hA7
`define FSPC_ADDR_TYPE     8'hF2
`define FSPC_ADDR_KEY1     8'hF3
`define FSPC_ADDR_KEY2     8'hF4
`define FSPC_ADDR_KEY3     8'hF5
`define FSPC_ADDR_KEY4     8'hF6
`define FSPC_ADDR_PAGE     8'hF7
`define FSPC_ADDR_OFFS     8'hFB
`define FSPC_ADDR_DATA     8'hFC
`define FSPC_TYPE_ERASE    8'hE6
`define FSPC_TYPE_PROG     8'h6E
`define FSPC_KEY1_VAL      4'h5
`define FSPC_KEY2_VAL      4'hA
`define FSPC_KEY3_VAL      4'h9
`define FSPC_KEY4_VAL      4'h6
`define FSPC_REG_RESET     8'h00
`define FSPC_KEY_RESET     4'h0
`define FSPC_NOP_CYCLES    4
`define FSPC_RAND_ADDR0    16'h127D
`define FSPC_RAND_ADDR2    16'h127F
`define FSPC_PROG_TIME_NS  20000
`define FSPC_ERASE_TIME_NS 2000000
`define FSPC_CLK_NS        8
`endif

// ### hdl/fspc_pkg.sv
// types shared by the flash self-programming sequencer
package fspc_pkg;
  typedef enum logic [4:0] {
    FSPC_IDLE  = 5'b00001,
    FSPC_ARMED = 5'b00010,
    FSPC_WAIT  = 5'b00100,
    FSPC_RUN   = 5'b01000,
    FSPC_DONE  = 5'b10000
  } fspc_state_type;
  typedef enum logic [1:0] {
    FSPC_OP_NONE  = 2'h0,
    FSPC_OP_ERASE = 2'h1,
    FSPC_OP_PROG  = 2'h2
  } fspc_op_type;
endpackage

// ### hdl/fspc_addr_map.sv
// flash target address and protection decode from page and offset
`timescale 1ns/10ps
`include "fspc_params.svh"
module fspc_addr_map
  import fspc_pkg::*;
(
  input  wire logic        area_sel,
  input  wire logic [7:0]  page,
  input  wire logic [7:0]  offset,
  input  wire logic [3:0]  prot_mode1_n,
  input  wire logic        prot_mode2,
  input  wire logic [3:0]  exec_sector,
  output logic      [13:0] addr,
  output logic             allowed
);
  always_comb
  begin
    if (area_sel)
    begin
      addr    = {3'h0, page[2:0], offset};
      allowed = 1'b1;
    end
    else
    begin
      addr    = {page[5:2], page[1:0], offset};
      // protection unit is four sectors; mode bits active mean locked
      allowed = prot_mode1_n[page[5:4]] && !prot_mode2;
    end
  end
  // erase of the running sector is refused in the top, which knows op type
  wire unused_ok = |{page[7:6], exec_sector};
endmodule

// ### hdl/fspc_unlock.sv
// four-step unlock key tracker; any wrong key in sequence drops it
`timescale 1ns/10ps
`include "fspc_params.svh"
module fspc_unlock
  import fspc_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic       type_wr,
  input  wire logic [3:0] key_wr,
  input  wire logic [3:0] key_val,
  input  wire logic       other_wr,
  output logic            unlocked
);
  typedef struct packed {
    logic [2:0] step;
    logic       ok;
  } fspc_ul_type;
  fspc_ul_type s_q;
  fspc_ul_type s_d;
  function automatic logic [3:0] expect_key(input logic [1:0] idx);
    unique case (idx)
      2'd0: expect_key = `FSPC_KEY1_VAL;
      2'd1: expect_key = `FSPC_KEY2_VAL;
      2'd2: expect_key = `FSPC_KEY3_VAL;
      2'd3: expect_key = `FSPC_KEY4_VAL;
    endcase
  endfunction
  always_comb
  begin
    s_d    = s_q;
    s_d.ok = 1'b0;
    if (type_wr)
      s_d.step = 3'd1;
    else if (|key_wr)
    begin
      // key must land on the expected register with the expected value
      if (s_q.step != 3'd0 && key_wr[s_q.step[1:0] - 2'd1]
          && key_val == expect_key(2'(s_q.step - 3'd1)))
      begin
        if (s_q.step == 3'd4)
        begin
          s_d.step = 3'd0;
          s_d.ok   = 1'b1;
        end
        else
          s_d.step = s_q.step + 3'd1;
      end
      else
        s_d.step = 3'd0;
    end
    else if (other_wr)
      s_d.step = 3'd0;
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end
  assign unlocked = s_q.ok;
  chk_wrong_key_drops: assert property (@(posedge ref_clk) disable iff (rst)
    (|key_wr && s_q.step == 3'd1 && key_val != `FSPC_KEY1_VAL) |=> !s_q.ok && s_q.step == 3'd0)
    else $error("wrong first key did not abort");
  chk_ok_needs_key4: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.ok |-> $past(key_wr[3]) && $past(key_val) == `FSPC_KEY4_VAL)
    else $error("unlock without fourth key");
endmodule

// ### hdl/fspc_ctrl.sv
// flash self-programming sequencer with its special function registers
`timescale 1ns/10ps
`include "fspc_params.svh"
// How it works
// - main array: page bits 5..2 pick the 1KB sector, bits 1..0 upper address
// - page bits 1..0 and offset form a 10-bit byte offset in the sector
// - second array: page bits 2..0 pick one of eight sectors, rest ignored
// - second array: full offset register addresses the 256-byte sector
// - program writes the data register byte to the addressed location
// - type register E6 means sector erase, 6E means byte program
// - first key must be 5 or the operation is abandoned
// - second key must be A or the operation is abandoned
// - third key must be 9 or the operation is abandoned
// - fourth key must be 6 or the operation is abandoned
// - cpu held idle during byte program, released on completion
// - cpu held idle during sector erase, released on completion
// - main-array program or erase refused unless protect modes 1 and 2 off
// - second-array operations ignore code protection
// - access select 0 targets main array, 1 the second array, for reads too
// - with access select, reads at 127D..127F return the random code
// - random code is fixed and no erase touches it
// - external programming mode follows the entry pin level three clocks later
// - erase of the sector holding running code is refused
module fspc_ctrl
  import fspc_pkg::*;
#(
  parameter int          PROG_CYCLES  = `FSPC_PROG_TIME_NS / `FSPC_CLK_NS,
  parameter int          ERASE_CYCLES = `FSPC_ERASE_TIME_NS / `FSPC_CLK_NS,
  // value arbitrary, stands in for the per-chip code fused at test
  parameter logic [23:0] RANDOM_CODE  = 24'h5A3C96
)
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_addr,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  input  wire logic        code_rd,
  input  wire logic [15:0] code_addr,
  output logic      [7:0]  code_rdata,
  input  wire logic [3:0]  prot_mode1_n,
  input  wire logic        prot_mode2,
  input  wire logic [15:0] exec_pc,
  input  wire logic        icp_entry,
  input  wire logic [7:0]  main_rdata,
  input  wire logic [7:0]  aux_rdata,
  input  wire logic        flash_done_pin,
  output logic             cpu_idle,
  output logic             flash_erase,
  output logic             flash_prog,
  output logic             flash_aux,
  output logic      [13:0] flash_addr,
  output logic      [7:0]  flash_wdata,
  output logic             icp_mode,
  output logic             op_refused
);
  typedef struct packed {
    fspc_state_type st;
    fspc_op_type    op;
    logic           area;
    logic [7:0]     typ;
    logic [3:0]     key1;
    logic [3:0]     key2;
    logic [3:0]     key3;
    logic [3:0]     key4;
    logic [7:0]     page;
    logic [7:0]     offs;
    logic [7:0]     data;
    logic [18:0]    cnt;
    logic [7:0]     rdata;
    logic [7:0]     crdata;
    logic           idle;
    logic           erase;
    logic           prog;
    logic           aux;
    logic [13:0]    faddr;
    logic [7:0]     fdata;
    logic [1:0]     icp_sync;
    logic [1:0]     done_sync;
    logic           in_circuit_programming;
    logic           refused;
  } fspc_top_type;
  fspc_top_type s_q;
  fspc_top_type s_d;
  logic [3:0]  key_wr;
  logic        type_wr;
  logic        unlocked;
  logic [13:0] map_addr;
  logic        map_ok;
  logic        self_sector;
  function automatic logic hit(input logic [7:0] a);
    hit = sfr_wr && sfr_addr == a;
  endfunction
  // decoded in a process so the strobes follow every change of the bus inputs
  always_comb
  begin
    key_wr  = {hit(`FSPC_ADDR_KEY4), hit(`FSPC_ADDR_KEY3),
               hit(`FSPC_ADDR_KEY2), hit(`FSPC_ADDR_KEY1)};
    type_wr = hit(`FSPC_ADDR_TYPE);
  end
  fspc_unlock fspc_unlock_i (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .type_wr  (type_wr),
    .key_wr   (key_wr),
    .key_val  (sfr_wdata[3:0]),
    .other_wr (sfr_wr),
    .unlocked (unlocked)
  );
  fspc_addr_map fspc_addr_map_i (
    .area_sel     (s_q.area),
    .page         (s_q.page),
    .offset       (s_q.offs),
    .prot_mode1_n (prot_mode1_n),
    .prot_mode2   (prot_mode2),
    .exec_sector  (exec_pc[13:10]),
    .addr         (map_addr),
    .allowed      (map_ok)
  );
  // code runs from the main array only, so only there can it erase itself
  assign self_sector = !s_q.area && s_q.page[5:2] == exec_pc[13:10];
  always_comb
  begin
    s_d           = s_q;
    s_d.icp_sync  = {s_q.icp_sync[0], icp_entry};
    s_d.done_sync = {s_q.done_sync[0], flash_done_pin};
    s_d.in_circuit_programming       = s_q.icp_sync[1];
    if (sfr_wr && s_q.st == FSPC_IDLE)
    begin
      unique case (sfr_addr)
        `FSPC_ADDR_AREA: s_d.area = sfr_wdata[0];
        `FSPC_ADDR_TYPE: s_d.typ  = sfr_wdata;
        `FSPC_ADDR_KEY1: s_d.key1 = sfr_wdata[3:0];
        `FSPC_ADDR_KEY2: s_d.key2 = sfr_wdata[3:0];
        `FSPC_ADDR_KEY3: s_d.key3 = sfr_wdata[3:0];
        `FSPC_ADDR_KEY4: s_d.key4 = sfr_wdata[3:0];
        `FSPC_ADDR_PAGE: s_d.page = sfr_wdata;
        `FSPC_ADDR_OFFS: s_d.offs = sfr_wdata;
        `FSPC_ADDR_DATA: s_d.data = sfr_wdata;
        default:         s_d.area = s_q.area;
      endcase
    end
    s_d.rdata = `FSPC_REG_RESET;
    if (sfr_rd)
    begin
      unique case (sfr_addr)
        `FSPC_ADDR_AREA: s_d.rdata = {7'h00, s_q.area};
        `FSPC_ADDR_TYPE: s_d.rdata = s_q.typ;
        `FSPC_ADDR_KEY1: s_d.rdata = {4'h0, s_q.key1};
        `FSPC_ADDR_KEY2: s_d.rdata = {4'h0, s_q.key2};
        `FSPC_ADDR_KEY3: s_d.rdata = {4'h0, s_q.key3};
        `FSPC_ADDR_KEY4: s_d.rdata = {4'h0, s_q.key4};
        `FSPC_ADDR_PAGE: s_d.rdata = s_q.page;
        `FSPC_ADDR_OFFS: s_d.rdata = s_q.offs;
        `FSPC_ADDR_DATA: s_d.rdata = s_q.data;
        default:         s_d.rdata = `FSPC_REG_RESET;
      endcase
    end
    if (code_rd)
    begin
      if (s_q.area && code_addr >= `FSPC_RAND_ADDR0 && code_addr <= `FSPC_RAND_ADDR2)
        // fused code, no path from erase logic reaches it
        s_d.crdata = RANDOM_CODE[8'(code_addr - `FSPC_RAND_ADDR0) * 8 +: 8];
      else if (s_q.area)
        s_d.crdata = aux_rdata;
      else
        s_d.crdata = main_rdata;
    end
    unique case (s_q.st)
      FSPC_IDLE:
      begin
        s_d.refused = 1'b0;
        if (unlocked)
        begin
          if (s_q.typ == `FSPC_TYPE_ERASE)
            s_d.op = FSPC_OP_ERASE;
          else if (s_q.typ == `FSPC_TYPE_PROG)
            s_d.op = FSPC_OP_PROG;
          else
            s_d.op = FSPC_OP_NONE;
          s_d.st = FSPC_ARMED;
        end
      end
      FSPC_ARMED:
      begin
        // refused requests never reach the array and leave the cpu running
        if (s_q.op == FSPC_OP_NONE || !map_ok
            || (s_q.op == FSPC_OP_ERASE && self_sector))
        begin
          s_d.refused = 1'b1;
          s_d.st      = FSPC_IDLE;
        end
        else
        begin
          s_d.cnt = 19'(`FSPC_NOP_CYCLES);
          s_d.st  = FSPC_WAIT;
        end
      end
      FSPC_WAIT:
      begin
        // room for the trailing nops before the core is parked
        if (s_q.cnt == 19'd1)
        begin
          s_d.idle  = 1'b1;
          s_d.erase = s_q.op == FSPC_OP_ERASE;
          s_d.prog  = s_q.op == FSPC_OP_PROG;
          s_d.aux   = s_q.area;
          s_d.faddr = map_addr;
          s_d.fdata = s_q.data;
          s_d.cnt   = s_q.op == FSPC_OP_ERASE ? 19'(ERASE_CYCLES) : 19'(PROG_CYCLES);
          s_d.st    = FSPC_RUN;
        end
        else
          s_d.cnt = s_q.cnt - 19'd1;
      end
      FSPC_RUN:
      begin
        if (s_q.cnt == 19'd1 || s_q.done_sync[1])
          s_d.st = FSPC_DONE;
        else
          s_d.cnt = s_q.cnt - 19'd1;
      end
      FSPC_DONE:
      begin
        s_d.idle  = 1'b0;
        s_d.erase = 1'b0;
        s_d.prog  = 1'b0;
        s_d.op    = FSPC_OP_NONE;
        s_d.st    = FSPC_IDLE;
      end
    endcase
  end
  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q    <= '0;
      s_q.st <= FSPC_IDLE;
    end
    else
      s_q <= s_d;
  end
  assign sfr_rdata   = s_q.rdata;
  assign code_rdata  = s_q.crdata;
  assign cpu_idle    = s_q.idle;
  assign flash_erase = s_q.erase;
  assign flash_prog  = s_q.prog;
  assign flash_aux   = s_q.aux;
  assign flash_addr  = s_q.faddr;
  assign flash_wdata = s_q.fdata;
  assign icp_mode    = s_q.in_circuit_programming;
  assign op_refused  = s_q.refused;
  chk_start_needs_unlock: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == FSPC_ARMED) |-> $past(unlocked))
    else $error("operation armed without unlock");
  chk_idle_while_prog: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.prog || s_q.erase) |-> s_q.idle)
    else $error("cpu not idle during flash operation");
  chk_idle_release: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == FSPC_DONE) |=> !s_q.idle && s_q.st == FSPC_IDLE)
    else $error("cpu not released after operation");
  chk_protect_refuse: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == FSPC_ARMED && !s_q.area && prot_mode2) |=> s_q.refused && !s_q.prog)
    else $error("protected main array not refused");
  chk_self_erase: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == FSPC_ARMED && s_q.op == FSPC_OP_ERASE && self_sector) |=> s_q.refused)
    else $error("running sector erase not refused");
  chk_nop_delay: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == FSPC_ARMED && !s_d.refused) |=> !s_q.idle [*4] ##1 s_q.idle)
    else $error("operation start not four cycles after arm");
  chk_prog_data: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_q.prog) |-> s_q.fdata == s_q.data)
    else $error("programmed byte differs from data register");
  chk_rand_read: assert property (@(posedge ref_clk) disable iff (rst)
    (code_rd && s_q.area && code_addr == `FSPC_RAND_ADDR0) |=> s_q.crdata == RANDOM_CODE[7:0])
    else $error("random code byte wrong");
  chk_erase_type: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_q.erase) |-> s_q.typ == `FSPC_TYPE_ERASE)
    else $error("erase started without erase type");
  chk_prog_type: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(s_q.prog) |-> s_q.typ == `FSPC_TYPE_PROG)
    else $error("program started without program type");
  chk_main_addr: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(s_q.idle) && !s_q.aux) |-> s_q.faddr == {s_q.page[5:0], s_q.offs})
    else $error("main array address wrong");
  chk_aux_addr: assert property (@(posedge ref_clk) disable iff (rst)
    ($rose(s_q.idle) && s_q.aux) |-> s_q.faddr == {3'h0, s_q.page[2:0], s_q.offs})
    else $error("second array address wrong");
  chk_aux_unprotected: assert property (@(posedge ref_clk) disable iff (rst)
    (s_q.st == FSPC_ARMED && s_q.area && s_q.op != FSPC_OP_NONE) |=> !s_q.refused)
    else $error("second array operation refused");
  chk_refuse_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.refused |-> !s_q.idle && !s_q.prog && !s_q.erase)
    else $error("refused operation reached the array");
  chk_refuse_pulse: assert property (@(posedge ref_clk) disable iff (rst)
    s_q.refused |=> !s_q.refused)
    else $error("refusal flag longer than one cycle");
endmodule

// ### tb/tb_fspc_ctrl.sv
// self-checking bench for the flash self-programming sequencer
`timescale 1ns/10ps
`include "fspc_params.svh"
module tb_fspc_ctrl;
  import fspc_pkg::*;
  localparam int          PROG_N  = 10;
  localparam int          ERASE_N = 12;
  // value arbitrary, any 24-bit pattern serves
  localparam logic [23:0] CODE    = 24'hC3A51E;
  localparam logic [7:0]  REGS [9] = '{`FSPC_ADDR_AREA, `FSPC_ADDR_TYPE, `FSPC_ADDR_KEY1,
    `FSPC_ADDR_KEY2, `FSPC_ADDR_KEY3, `FSPC_ADDR_KEY4, `FSPC_ADDR_PAGE, `FSPC_ADDR_OFFS,
    `FSPC_ADDR_DATA};
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        sfr_wr = 1'b0, sfr_rd = 1'b0, code_rd = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, main_rdata = 8'h00, aux_rdata = 8'h00;
  logic [15:0] code_addr = 16'h0000, exec_pc = 16'h0000;
  logic [3:0]  prot_mode1_n = 4'hF;
  logic        prot_mode2 = 1'b0, icp_entry = 1'b0, flash_done_pin = 1'b0;
  logic [7:0]  sfr_rdata, code_rdata, flash_wdata;
  logic        cpu_idle, flash_erase, flash_prog, flash_aux, icp_mode, op_refused;
  logic [13:0] flash_addr;
  logic [31:0] seed = 32'h00003798;
  logic [25:0] exp_op [$];
  logic [7:0]  exp_rd [$];
  int          exp_len [$];
  int          fails = 0, n_checks = 0, cnt = 0;
  logic        rd_p = 1'b0, cr_p = 1'b0, run_p = 1'b0;
  logic [31:0] r;
  fspc_ctrl #(.PROG_CYCLES(PROG_N), .ERASE_CYCLES(ERASE_N), .RANDOM_CODE(CODE)) fspc_ctrl_i (
    .ref_clk(ref_clk), .rst(rst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .code_rd(code_rd), .code_addr(code_addr),
    .code_rdata(code_rdata), .prot_mode1_n(prot_mode1_n), .prot_mode2(prot_mode2),
    .exec_pc(exec_pc), .icp_entry(icp_entry), .main_rdata(main_rdata), .aux_rdata(aux_rdata),
    .flash_done_pin(flash_done_pin), .cpu_idle(cpu_idle), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .flash_aux(flash_aux), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .icp_mode(icp_mode), .op_refused(op_refused));
  always #4 ref_clk = ~ref_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(string what, logic [31:0] e, logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic take_op(logic [25:0] g);
    if (exp_op.size() == 0)
      check("unexpected operation", 26'h0, g);
    else
      check("operation", exp_op.pop_front(), g);
  endtask
  // watcher: pairs every visible result with the oldest note
  always @(posedge ref_clk)
  begin
    rd_p <= sfr_rd;
    cr_p <= code_rd;
    run_p <= flash_prog | flash_erase;
    if (rd_p || cr_p)
    begin
      if (exp_rd.size() == 0)
        check("read count", 1, 0);
      else
        check(rd_p ? "sfr_rdata" : "code_rdata", exp_rd.pop_front(),
              rd_p ? sfr_rdata : code_rdata);
    end
    if (op_refused === 1'b1)
      take_op({1'b1, 25'h0});
    if ((flash_prog | flash_erase) === 1'b1)
      cnt <= cnt + 1;
    if ((flash_prog | flash_erase) === 1'b1 && !run_p)
    begin
      // erase address is judged on its sector bits only
      take_op({1'b0, flash_erase, flash_prog, flash_aux, flash_erase ?
        flash_addr & (flash_aux ? 14'h3F00 : 14'h3C00) : flash_addr,
        flash_erase ? 8'h00 : flash_wdata});
      check("cpu_idle", 1, cpu_idle);
    end
    if ((flash_prog | flash_erase) === 1'b0 && run_p)
    begin
      // the completion step adds exactly one cycle to the stated run time
      check("run length", 1, exp_len.size() > 0 && cnt == exp_len[0] + 1);
      if (exp_len.size() > 0)
        void'(exp_len.pop_front());
      cnt <= 0;
    end
  end
  task automatic wr(logic [7:0] a, logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge ref_clk);
    sfr_wr <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    exp_rd.push_back(e);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    @(posedge ref_clk);
    sfr_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic crd(logic [15:0] a, logic [7:0] m, logic [7:0] x, logic [7:0] e);
    exp_rd.push_back(e);
    code_addr <= a;
    main_rdata <= m;
    aux_rdata <= x;
    code_rd <= 1'b1;
    @(posedge ref_clk);
    code_rd <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wait_lvl(logic v);
    int i;
    i = 0;
    while (cpu_idle !== v && i < 100)
    begin
      @(posedge ref_clk);
      i++;
    end
    if (i == 100)
    begin
      fails++;
      $display("mismatch cpu_idle expected %b seen timeout", v);
      wrap_up();
    end
  endtask
  // res 0 runs, 1 is refused, 2 is dropped without a word
  task automatic op(logic fac, logic [7:0] pg, logic [7:0] of, logic [7:0] dt, logic [7:0] ty,
                    logic [15:0] k, int res);
    logic        er;
    logic [13:0] ad;
    er = (ty == `FSPC_TYPE_ERASE);
    ad = fac ? {3'b000, pg[2:0], of} : {pg[5:0], of};
    if (er)
      ad = ad & (fac ? 14'h3F00 : 14'h3C00);
    if (res == 1)
      exp_op.push_back({1'b1, 25'h0});
    if (res == 0)
    begin
      exp_op.push_back({1'b0, er, !er, fac, ad, er ? 8'h00 : dt});
      exp_len.push_back(er ? ERASE_N : PROG_N);
    end
    wr(`FSPC_ADDR_AREA, {7'h00, fac});
    wr(`FSPC_ADDR_PAGE, pg);
    wr(`FSPC_ADDR_OFFS, of);
    wr(`FSPC_ADDR_DATA, dt);
    wr(`FSPC_ADDR_TYPE, ty);
    for (int i = 0; i < 4; i++)
      wr(REGS[2 + i], {4'h0, k[15 - 4 * i -: 4]});
    repeat (`FSPC_NOP_CYCLES) @(posedge ref_clk);
    if (res == 0)
    begin
      wait_lvl(1'b1);
      wait_lvl(1'b0);
    end
    repeat (8) @(posedge ref_clk);
  endtask
  initial
  begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (REGS[i])
      rd(REGS[i], `FSPC_REG_RESET);
    rd(8'h80, 8'h00);
    foreach (REGS[i])
    begin
      r = rnd() | 32'h8;
      wr(REGS[i], r[7:0]);
      rd(REGS[i], i == 0 ? {7'h00, r[0]} : (i < 6 && i > 1) ? {4'h0, r[3:0]} : r[7:0]);
    end
    $display("test registers done");
    for (int n = 0; n < 10; n++)
    begin
      r = rnd();
      exec_pc <= {2'b00, ~r[13:10], 10'h000};
      op(r[0], r[15:8], r[23:16], r[31:24], r[1] ? `FSPC_TYPE_ERASE : `FSPC_TYPE_PROG,
         16'h5A96, 0);
    end
    wr(`FSPC_ADDR_PAGE, 8'h00);
    $display("test operations done");
    prot_mode1_n <= 4'b1011;
    op(1'b0, 8'h24, 8'h11, 8'h3C, `FSPC_TYPE_PROG, 16'h5A96, 1);
    prot_mode1_n <= 4'hF;
    prot_mode2 <= 1'b1;
    op(1'b0, 8'h24, 8'h11, 8'h3C, `FSPC_TYPE_ERASE, 16'h5A96, 1);
    prot_mode1_n <= 4'h0;
    op(1'b1, 8'hFD, 8'hC7, 8'h81, `FSPC_TYPE_PROG, 16'h5A96, 0);
    prot_mode1_n <= 4'hF;
    prot_mode2 <= 1'b0;
    exec_pc <= 16'h2555;
    op(1'b0, 8'h24, 8'h00, 8'h00, `FSPC_TYPE_ERASE, 16'h5A96, 1);
    op(1'b0, 8'h08, 8'h00, 8'h00, 8'h66, 16'h5A96, 1);
    $display("test refusals done");
    for (int i = 0; i < 4; i++)
      op(1'b0, 8'h08, 8'h01, 8'h02, `FSPC_TYPE_PROG,
         16'h5A96 ^ (16'h1 << (12 - 4 * i)), 2);
    wr(`FSPC_ADDR_TYPE, `FSPC_TYPE_PROG);
    wr(`FSPC_ADDR_KEY1, 8'h05);
    wr(`FSPC_ADDR_KEY2, 8'h0A);
    wr(`FSPC_ADDR_PAGE, 8'h08);
    wr(`FSPC_ADDR_KEY3, 8'h09);
    wr(`FSPC_ADDR_KEY4, 8'h06);
    repeat (12) @(posedge ref_clk);
    $display("test keys done");
    for (int n = 0; n < 4; n++)
    begin
      r = rnd();
      wr(`FSPC_ADDR_AREA, {7'h00, r[0]});
      crd({6'h01, r[9:0]}, r[23:16], r[31:24], r[0] ? r[31:24] : r[23:16]);
    end
    wr(`FSPC_ADDR_AREA, 8'h01);
    for (int i = 0; i < 3; i++)
      crd(`FSPC_RAND_ADDR0 + i, 8'h00, 8'hFF, CODE[8 * i +: 8]);
    wr(`FSPC_ADDR_AREA, 8'h00);
    crd(`FSPC_RAND_ADDR0, 8'h77, 8'hFF, 8'h77);
    $display("test code reads done");
    icp_entry <= 1'b1;
    repeat (5) @(posedge ref_clk);
    check("icp_mode", 1, icp_mode);
    icp_entry <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check("icp_mode", 0, icp_mode);
    check("pending notes", 0, exp_op.size() + exp_rd.size() + exp_len.size());
    $display("test programming entry done");
    wrap_up();
  end
endmodule
